/* File: cif_pkg.sv */
// constants and carrier types of the core interrupt flag and enable logic
package cif_pkg;
   // register bus geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   // register locations; the core control word is mirrored in every bank
   localparam logic [ADDR_W-1:0] CORE_CTRL_ADDR = 9'h00B;
   localparam logic [ADDR_W-1:0] BANK_OFFSET_MASK = 9'h07F;
   localparam logic [ADDR_W-1:0] PERIPH_FLAGS_ADDR = 9'h00C;
   // core control field positions
   localparam int GLOBAL_EN_BIT = 7;
   localparam int PERIPH_GRP_EN_BIT = 6;
   localparam int T0_EN_BIT = 5;
   localparam int EXT_EN_BIT = 4;
   localparam int PORT_EN_BIT = 3;
   localparam int T0_FLAG_BIT = 2;
   localparam int EXT_FLAG_BIT = 1;
   localparam int PORT_FLAG_BIT = 0;
   localparam int CORE_FLAG_W = 3;
   localparam int CORE_EN_W = 5;
   // peripheral flag field positions
   localparam int PSP_FLAG_BIT = 7;
   localparam int ADC_FLAG_BIT = 6;
   localparam int RX_FLAG_BIT = 5;
   localparam int TX_FLAG_BIT = 4;
   localparam int SSP_FLAG_BIT = 3;
   localparam int CCP_FLAG_BIT = 2;
   localparam int TMR2_FLAG_BIT = 1;
   localparam int TMR1_FLAG_BIT = 0;
   localparam int PERIPH_STICKY_W = 6;
   // reset values
   localparam logic [CORE_EN_W-1:0] CORE_EN_RESET = 5'h00;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
   localparam logic [DATA_W-1:0] PERIPH_FLAGS_RESET = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } cif_bus_req_t;

   // event inputs; pulses except rx_full and tx_empty, which are buffer levels
   typedef struct packed {
      logic t0_overflow;
      logic port_mismatch;
      logic psp_done;
      logic adc_done;
      logic rx_full;
      logic tx_empty;
      logic ssp_done;
      logic ccp_event;
      logic tmr2_match;
      logic tmr1_overflow;
   } cif_events_t;
endpackage : cif_pkg

/* File: cif_flag_cell.sv */
// bank of sticky flag bits, set by hardware and written by software
`timescale 1ns/1ps
`default_nettype none
module cif_flag_cell #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // hardware events and software write
   input wire logic [WIDTH-1:0] set,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_val,
   // flag state
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } cif_cell_state_t;

   cif_cell_state_t state_ff;
   cif_cell_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (wr_en) begin
         nxt_state.flags = wr_val;
      end
      // an event in the clearing cycle must survive the write
      nxt_state.flags = nxt_state.flags | set;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= '{flags: RESET_VAL};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign q = state_ff.flags;
endmodule : cif_flag_cell
`default_nettype wire

/* File: cif_top.sv */
// core interrupt enables, flags and request logic with its register port
//
// Summary of operation
// - each flag sets on its event whatever the enable and global enable bits say.
// - global enable bit 7 gates every interrupt request; zero blocks them all.
// - peripheral group enable bit 6 passes or blocks all peripheral requests.
// - bit 4 enables the external edge pin interrupt.
// - core control register is read-write; all bits reset to zero.
// - core control register answers at its offset in all four banks.
// - peripheral flag register holds one flag per peripheral source.
// - serial receive flag bit 5 is read-only and mirrors receive buffer full.
// - sync serial flag bit 3 is zero until a transfer or bus event completes.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cif_top (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire cif_pkg::cif_bus_req_t bus_req,
   output logic [cif_pkg::DATA_W-1:0] rdata,
   // event sources
   input wire cif_pkg::cif_events_t events,
   input wire logic external_edge_pin,
   input wire logic ext_edge_rising,
   // peripheral source enables, held outside this block
   input wire logic [cif_pkg::DATA_W-1:0] periph_enable,
   // request to the core
   output logic irq
);
   typedef struct packed {
      logic [cif_pkg::CORE_EN_W-1:0] core_en;
      logic [cif_pkg::DATA_W-1:0] rdata;
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
   } cif_top_state_t;

   cif_top_state_t state_ff;
   cif_top_state_t nxt_state;

   logic core_hit;
   logic periph_hit;
   logic core_wr;
   logic periph_wr;
   logic ext_edge;
   logic [cif_pkg::CORE_FLAG_W-1:0] core_flag_set;
   logic [cif_pkg::CORE_FLAG_W-1:0] core_flags;
   logic [cif_pkg::PERIPH_STICKY_W-1:0] periph_flag_set;
   logic [cif_pkg::PERIPH_STICKY_W-1:0] periph_wr_val;
   logic [cif_pkg::PERIPH_STICKY_W-1:0] periph_sticky;
   logic [cif_pkg::DATA_W-1:0] core_value;
   logic [cif_pkg::DATA_W-1:0] periph_value;
   logic global_en;
   logic group_en;
   logic core_any;
   logic periph_any;

   // the control word ignores bank select bits so all mirrors hit one register
   assign core_hit = (bus_req.addr & cif_pkg::BANK_OFFSET_MASK)
                     == cif_pkg::CORE_CTRL_ADDR;
   assign periph_hit = bus_req.addr == cif_pkg::PERIPH_FLAGS_ADDR;
   assign core_wr = bus_req.wr && core_hit;
   assign periph_wr = bus_req.wr && periph_hit;

   // only the synchronised copy and its delayed twin feed the edge detector
   assign ext_edge = ext_edge_rising ? (state_ff.pin_sync && !state_ff.pin_prev)
                                     : (!state_ff.pin_sync && state_ff.pin_prev);

   // events set flags with no regard to any enable bit
   assign core_flag_set = {events.t0_overflow, ext_edge, events.port_mismatch};
   assign periph_flag_set = {events.psp_done, events.adc_done, events.ssp_done,
                             events.ccp_event, events.tmr2_match,
                             events.tmr1_overflow};
   assign periph_wr_val = {bus_req.wdata[cif_pkg::PSP_FLAG_BIT],
                           bus_req.wdata[cif_pkg::ADC_FLAG_BIT],
                           bus_req.wdata[cif_pkg::SSP_FLAG_BIT],
                           bus_req.wdata[cif_pkg::CCP_FLAG_BIT],
                           bus_req.wdata[cif_pkg::TMR2_FLAG_BIT],
                           bus_req.wdata[cif_pkg::TMR1_FLAG_BIT]};

   // port change flag comes out of reset cleared, a defined choice for an unknown
   cif_flag_cell #(
      .WIDTH(cif_pkg::CORE_FLAG_W),
      .RESET_VAL(3'h0)
   ) u_core_flags (
      .clock(clock),
      .rst(rst),
      .set(core_flag_set),
      .wr_en(core_wr),
      .wr_val(bus_req.wdata[cif_pkg::CORE_FLAG_W-1:0]),
      .q(core_flags)
   );

   cif_flag_cell #(
      .WIDTH(cif_pkg::PERIPH_STICKY_W),
      .RESET_VAL(6'h00)
   ) u_periph_flags (
      .clock(clock),
      .rst(rst),
      .set(periph_flag_set),
      .wr_en(periph_wr),
      .wr_val(periph_wr_val),
      .q(periph_sticky)
   );

   assign core_value = {state_ff.core_en, core_flags};
   // receive and transmit flags are live buffer levels, writes do not touch them
   assign periph_value = {periph_sticky[5], periph_sticky[4], events.rx_full,
                          events.tx_empty, periph_sticky[3], periph_sticky[2],
                          periph_sticky[1], periph_sticky[0]};

   always_comb begin
      nxt_state = state_ff;
      nxt_state.pin_meta = external_edge_pin;
      nxt_state.pin_sync = state_ff.pin_meta;
      nxt_state.pin_prev = state_ff.pin_sync;
      if (core_wr) begin
         nxt_state.core_en = bus_req.wdata[cif_pkg::DATA_W-1:cif_pkg::CORE_FLAG_W];
      end
      // read data stand for one cycle only, zero otherwise and on a miss
      nxt_state.rdata = cif_pkg::READ_IDLE;
      if (bus_req.rd) begin
         if (core_hit) begin
            nxt_state.rdata = core_value;
         end else if (periph_hit) begin
            nxt_state.rdata = periph_value;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= '{core_en: cif_pkg::CORE_EN_RESET, rdata: cif_pkg::READ_IDLE,
                       pin_meta: 1'b0, pin_sync: 1'b0, pin_prev: 1'b0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign global_en = core_value[cif_pkg::GLOBAL_EN_BIT];
   assign group_en = core_value[cif_pkg::PERIPH_GRP_EN_BIT];
   assign core_any = (core_value[cif_pkg::T0_EN_BIT] && core_value[cif_pkg::T0_FLAG_BIT])
                  || (core_value[cif_pkg::EXT_EN_BIT]
                      && core_value[cif_pkg::EXT_FLAG_BIT])
                  || (core_value[cif_pkg::PORT_EN_BIT]
                      && core_value[cif_pkg::PORT_FLAG_BIT]);
   assign periph_any = |(periph_enable & periph_value);
   // level request; the core masks it further while it services one
   assign irq = global_en && (core_any || (group_en && periph_any));
   assign rdata = state_ff.rdata;

   // timer zero overflow lands in its flag even while disabled
   property p_flag_sets;
      @(posedge clock) disable iff (rst)
      events.t0_overflow |=> core_value[cif_pkg::T0_FLAG_BIT];
   endproperty
   chk_flag_sets_free: assert property (p_flag_sets)
      else $error("timer zero flag did not set on overflow");

   chk_global_gate: assert property (
      @(posedge clock) disable iff (rst)
      !global_en |-> !irq)
      else $error("request raised with global enable clear");

   chk_group_gate: assert property (
      @(posedge clock) disable iff (rst)
      (!group_en && !core_any) |-> !irq)
      else $error("peripheral request passed a cleared group enable");

   chk_ext_enable: assert property (
      @(posedge clock) disable iff (rst)
      (global_en && core_value[cif_pkg::EXT_EN_BIT] && core_value[cif_pkg::EXT_FLAG_BIT])
      |-> irq)
      else $error("enabled external edge flag gave no request");

   chk_reset_zero: assert property (
      @(posedge clock) $fell(rst) |-> (core_value == 8'h00 && rdata == 8'h00))
      else $error("control register not zero after reset");

   chk_mirror_read: assert property (
      @(posedge clock) disable iff (rst)
      (bus_req.rd && core_hit && !core_wr) |=> rdata == $past(core_value))
      else $error("mirrored control read returned wrong value");

   chk_periph_read: assert property (
      @(posedge clock) disable iff (rst)
      (bus_req.rd && periph_hit) ##1 !bus_req.rd |-> ##1 rdata == 8'h00)
      else $error("read data stood past its cycle");

   chk_rx_live: assert property (
      @(posedge clock) disable iff (rst)
      (bus_req.rd && periph_hit) |=> rdata[cif_pkg::RX_FLAG_BIT] == $past(events.rx_full))
      else $error("receive flag did not follow the buffer level");

   chk_sync_clear: assert property (
      @(posedge clock) disable iff (rst)
      (periph_wr && !bus_req.wdata[cif_pkg::SSP_FLAG_BIT] && !events.ssp_done)
      |=> !periph_value[cif_pkg::SSP_FLAG_BIT])
      else $error("sync serial flag not cleared by write of zero");

   chk_irq_periph: assert property (
      @(posedge clock) disable iff (rst)
      (global_en && group_en && periph_any) |-> irq)
      else $error("enabled peripheral flag gave no request");

   chk_sticky_hold: assert property (
      @(posedge clock) disable iff (rst)
      (core_value[cif_pkg::EXT_FLAG_BIT] && !core_wr) |=> core_value[cif_pkg::EXT_FLAG_BIT])
      else $error("external edge flag dropped without a write");

   chk_set_wins: assert property (
      @(posedge clock) disable iff (rst)
      (periph_wr && events.tmr1_overflow) |=> periph_value[cif_pkg::TMR1_FLAG_BIT])
      else $error("event lost against a clearing write");

   // flags follow their sources whatever the enables hold
   chk_ext_sets_free: assert property (
      @(posedge clock) disable iff (rst)
      ext_edge |=> core_value[cif_pkg::EXT_FLAG_BIT])
      else $error("external edge flag did not set");

   chk_port_sets_free: assert property (
      @(posedge clock) disable iff (rst)
      events.port_mismatch |=> core_value[cif_pkg::PORT_FLAG_BIT])
      else $error("port change flag did not set");

   chk_psp_sets_free: assert property (
      @(posedge clock) disable iff (rst)
      events.psp_done |=> periph_value[cif_pkg::PSP_FLAG_BIT])
      else $error("parallel slave flag did not set");

   chk_adc_sets_free: assert property (
      @(posedge clock) disable iff (rst)
      events.adc_done |=> periph_value[cif_pkg::ADC_FLAG_BIT])
      else $error("conversion flag did not set");

   chk_ccp_sets_free: assert property (
      @(posedge clock) disable iff (rst)
      events.ccp_event |=> periph_value[cif_pkg::CCP_FLAG_BIT])
      else $error("capture compare flag did not set");

   chk_tmr2_sets_free: assert property (
      @(posedge clock) disable iff (rst)
      events.tmr2_match |=> periph_value[cif_pkg::TMR2_FLAG_BIT])
      else $error("timer two match flag did not set");

   chk_tmr1_sets_free: assert property (
      @(posedge clock) disable iff (rst)
      events.tmr1_overflow |=> periph_value[cif_pkg::TMR1_FLAG_BIT])
      else $error("timer one overflow flag did not set");

   chk_sync_sets: assert property (
      @(posedge clock) disable iff (rst)
      events.ssp_done |=> periph_value[cif_pkg::SSP_FLAG_BIT])
      else $error("sync serial flag did not set on completion");

   chk_t0_request: assert property (
      @(posedge clock) disable iff (rst)
      (global_en && core_value[cif_pkg::T0_EN_BIT] && core_value[cif_pkg::T0_FLAG_BIT]) |-> irq)
      else $error("enabled timer zero flag gave no request");

   chk_port_request: assert property (
      @(posedge clock) disable iff (rst)
      (global_en && core_value[cif_pkg::PORT_EN_BIT] && core_value[cif_pkg::PORT_FLAG_BIT]) |-> irq)
      else $error("enabled port change flag gave no request");

   chk_t0_masked: assert property (
      @(posedge clock) disable iff (rst)
      (!core_value[cif_pkg::T0_EN_BIT] && !core_value[cif_pkg::EXT_FLAG_BIT]
       && !core_value[cif_pkg::PORT_FLAG_BIT] && !group_en) |-> !irq)
      else $error("masked timer zero flag raised a request");

   chk_ext_masked: assert property (
      @(posedge clock) disable iff (rst)
      (!core_value[cif_pkg::EXT_EN_BIT] && !group_en
       && !(core_value[cif_pkg::T0_EN_BIT] && core_value[cif_pkg::T0_FLAG_BIT])
       && !(core_value[cif_pkg::PORT_EN_BIT] && core_value[cif_pkg::PORT_FLAG_BIT]))
      |-> !irq)
      else $error("masked external edge flag raised a request");

   chk_core_write: assert property (
      @(posedge clock) disable iff (rst)
      core_wr |=> core_value[cif_pkg::DATA_W-1:cif_pkg::CORE_FLAG_W]
                  == $past(bus_req.wdata[cif_pkg::DATA_W-1:cif_pkg::CORE_FLAG_W]))
      else $error("control enables did not take the written value");

   chk_enable_hold: assert property (
      @(posedge clock) disable iff (rst)
      !core_wr |=> $stable(core_value[cif_pkg::DATA_W-1:cif_pkg::CORE_FLAG_W]))
      else $error("control enables changed without a write");

   // read port answers once, then idles at zero
   chk_core_read_once: assert property (
      @(posedge clock) disable iff (rst)
      (bus_req.rd && core_hit) ##1 !bus_req.rd |-> ##1 rdata == 8'h00)
      else $error("control read data stood past its cycle");

   chk_unmapped_read: assert property (
      @(posedge clock) disable iff (rst)
      (bus_req.rd && !core_hit && !periph_hit) |=> rdata == 8'h00)
      else $error("unmapped read returned nonzero data");

   chk_idle_read: assert property (
      @(posedge clock) disable iff (rst)
      !bus_req.rd |=> rdata == cif_pkg::READ_IDLE)
      else $error("read data present without a read");

   chk_periph_readback: assert property (
      @(posedge clock) disable iff (rst)
      (bus_req.rd && periph_hit) |=> rdata == $past(periph_value))
      else $error("peripheral flag read returned wrong value");

   chk_tx_live: assert property (
      @(posedge clock) disable iff (rst)
      (bus_req.rd && periph_hit) |=> rdata[cif_pkg::TX_FLAG_BIT] == $past(events.tx_empty))
      else $error("transmit flag did not follow the buffer level");

   chk_periph_hold: assert property (
      @(posedge clock) disable iff (rst)
      (periph_value[cif_pkg::ADC_FLAG_BIT] && !periph_wr) |=> periph_value[cif_pkg::ADC_FLAG_BIT])
      else $error("conversion flag dropped without a write");

   chk_periph_clear: assert property (
      @(posedge clock) disable iff (rst)
      (periph_wr && !bus_req.wdata[cif_pkg::ADC_FLAG_BIT] && !events.adc_done)
      |=> !periph_value[cif_pkg::ADC_FLAG_BIT])
      else $error("conversion flag not cleared by write of zero");

   chk_core_clear: assert property (
      @(posedge clock) disable iff (rst)
      (core_wr && !bus_req.wdata[cif_pkg::T0_FLAG_BIT] && !events.t0_overflow)
      |=> !core_value[cif_pkg::T0_FLAG_BIT])
      else $error("timer zero flag not cleared by write of zero");

   cov_irq_rise: cover property (@(posedge clock) disable iff (rst) $rose(irq));
   cov_clear_clash: cover property (@(posedge clock) disable iff (rst)
      core_wr && events.t0_overflow && !bus_req.wdata[cif_pkg::T0_FLAG_BIT]);
   cov_high_mirror: cover property (@(posedge clock) disable iff (rst)
      core_wr && bus_req.addr == 9'h18B);
   cov_ext_edge: cover property (@(posedge clock) disable iff (rst) ext_edge);
   cov_periph_clash: cover property (@(posedge clock) disable iff (rst)
      periph_wr && events.tmr1_overflow);
endmodule : cif_top
`default_nettype wire

/* File: cif_core_model.sv */
// core-side model: issues register accesses to the interrupt block
`timescale 1ns/1ps
`default_nettype none
module cif_core_model (
   // clock
   input wire logic clock,
   // register port
   output var cif_pkg::cif_bus_req_t bus_req,
   input wire logic [cif_pkg::DATA_W-1:0] rdata
);
   initial bus_req = '0;

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask : wr

   // data only valid in the single cycle after the strobe
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // stale flags wiped before any source is enabled
   task automatic arm(input logic [7:0] en);
      wr(cif_pkg::CORE_CTRL_ADDR, 8'h00);
      wr(cif_pkg::CORE_CTRL_ADDR, en);
   endtask : arm
endmodule : cif_core_model
`default_nettype wire

/* File: core_interrupt_flags_enables_bench.sv */
// self-checking bench for the core interrupt flag and enable block
`timescale 1ns/1ps
`default_nettype none
module core_interrupt_flags_enables_bench;
   localparam logic [8:0] CTRL = cif_pkg::CORE_CTRL_ADDR;
   localparam logic [8:0] PER = cif_pkg::PERIPH_FLAGS_ADDR;
   logic clock, rst, external_edge_pin, ext_edge_rising, irq;
   cif_pkg::cif_bus_req_t bus_req;
   cif_pkg::cif_events_t events;
   logic [7:0] rdata, periph_enable, rd_val;
   int fails, num_checks;

   cif_top dut (.clock(clock), .rst(rst), .bus_req(bus_req), .rdata(rdata), .events(events),
      .external_edge_pin(external_edge_pin), .ext_edge_rising(ext_edge_rising),
      .periph_enable(periph_enable), .irq(irq));
   cif_core_model core (.clock(clock), .bus_req(bus_req), .rdata(rdata));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic end_of_test();
      if (fails == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t reg exp %h got %h", $time, exp, got);
      end
   endtask : chk_reg

   task automatic chk_irq(input logic exp);
      num_checks++;
      if (irq !== exp) begin
         fails++;
         $display("[FAIL] %0t irq exp %h got %h", $time, exp, irq);
      end
   endtask : chk_irq

   task automatic read_chk(input logic [8:0] a, input logic [7:0] exp);
      core.rd(a, rd_val);
      chk_reg(exp, rd_val);
   endtask : read_chk

   // event bits: t0 9, port 8, psp 7, adc 6, rx 5, tx 4, ssp 3, ccp 2, tmr2 1, tmr1 0
   task automatic pulse(input logic [9:0] m);
      @(posedge clock);
      events <= events | m;
      @(posedge clock);
      events <= events & ~m;
   endtask : pulse

   // synchroniser plus edge detect takes a few cycles
   task automatic wait_irq();
      for (int n = 0; n < 10 && irq !== 1'b1; n++) @(posedge clock);
      #1;
      if (irq !== 1'b1) begin
         fails++;
         end_of_test();
      end
   endtask : wait_irq

   task automatic reset_values();
      read_chk(CTRL, 8'h00);
      read_chk(PER, 8'h00);
      chk_irq(1'b0);
   endtask : reset_values

   task automatic mirrors();
      core.wr(9'h08B, 8'h38);
      read_chk(9'h00B, 8'h38);
      read_chk(9'h10B, 8'h38);
      read_chk(9'h18B, 8'h38);
      read_chk(9'h00D, 8'h00);
      core.wr(9'h18B, 8'h00);
      read_chk(9'h08B, 8'h00);
   endtask : mirrors

   task automatic core_flags();
      pulse(10'h300);
      read_chk(CTRL, 8'h05);
      core.wr(CTRL, 8'h25);
      #1 chk_irq(1'b0);
      core.wr(CTRL, 8'hA5);
      #1 chk_irq(1'b1);
      core.wr(CTRL, 8'hA1);
      #1 chk_irq(1'b0);
      fork
         core.wr(CTRL, 8'hA0);
         pulse(10'h200);
      join
      read_chk(CTRL, 8'hA4);
      chk_irq(1'b1);
      core.wr(CTRL, 8'h00);
   endtask : core_flags

   task automatic ext_edge();
      core.arm(8'h90);
      external_edge_pin <= 1'b1;
      wait_irq();
      chk_irq(1'b1);
      read_chk(CTRL, 8'h92);
      core.wr(CTRL, 8'h82);
      #1 chk_irq(1'b0);
      @(posedge clock);
      ext_edge_rising <= 1'b0;
      core.arm(8'h90);
      external_edge_pin <= 1'b0;
      wait_irq();
      chk_irq(1'b1);
      core.wr(CTRL, 8'h00);
   endtask : ext_edge

   task automatic periph();
      periph_enable <= 8'hFF;
      events <= events | 10'h020;
      pulse(10'h048);
      read_chk(PER, 8'h68);
      core.wr(CTRL, 8'h40);
      #1 chk_irq(1'b0);
      core.wr(CTRL, 8'h80);
      #1 chk_irq(1'b0);
      core.wr(CTRL, 8'hC0);
      #1 chk_irq(1'b1);
      core.wr(PER, 8'h00);
      read_chk(PER, 8'h20);
      @(posedge clock);
      events <= events & ~10'h020;
      read_chk(PER, 8'h00);
      core.wr(PER, 8'hFF);
      read_chk(PER, 8'hCF);
      fork
         core.wr(PER, 8'h00);
         pulse(10'h087);
      join
      read_chk(PER, 8'h87);
      @(posedge clock);
      events <= events | 10'h010;
      read_chk(PER, 8'h97);
      @(posedge clock);
      events <= events & ~10'h010;
      periph_enable <= 8'h00;
      @(posedge clock);
      #1 chk_irq(1'b0);
   endtask : periph

   initial begin
      rst = 1'b1;
      events = '0;
      external_edge_pin = 1'b0;
      ext_edge_rising = 1'b1;
      periph_enable = 8'h00;
      fails = 0;
      num_checks = 0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      reset_values();
      mirrors();
      core_flags();
      ext_edge();
      periph();
      end_of_test();
   end
endmodule : core_interrupt_flags_enables_bench
`default_nettype wire
